//--- design/lin_evt_status.sv
// sticky event status with write-one-to-clear, mask and level interrupt
`timescale 1ns/10ps
`default_nettype none
module lin_evt_status
  import lin_irq_pkg::*;
#(
  parameter int WIDTH = EVT_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] event_i,
  input wire logic [WIDTH-1:0] clear_i,
  input wire logic [WIDTH-1:0] mask_i,
  output logic [WIDTH-1:0] status_o,
  output logic irq_o
);

  // refuse a width that leaves no status bit to hold an event
  if (WIDTH < 1) begin : g_bad_width
    $error("lin_evt_status: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] status_reg;
  logic [WIDTH-1:0] status_next;

  // set wins over a clear arriving in the same cycle
  assign status_next = (status_reg & ~clear_i) | event_i;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  assign status_o = status_reg;
  assign irq_o = |(status_reg & mask_i);

endmodule : lin_evt_status
`default_nettype wire

//--- design/lin_interrupt_enable_set.sv
// interrupt-enable set register of a lin / uart-compatible serial controller
// Notes on behaviour
// [RULE1] writing one sets enable, zero keeps it
// [RULE2] read returns current enables, any access mode
// [RULE3] bit 31 enables bit-error request, lin only
// [RULE4] bit 30 enables bus-fault request, lin only
// [RULE5] bit 29 enables checksum request, lin only
// [RULE6] bit 28 enables bad sync request, lin only
// [RULE7] bit 27 enables missing response request, lin only
// [RULE8] lin-only bits writable only in lin mode
// [RULE9] break-detect bit 0 writable only in uart mode
// [RULE10] bits 9, 8, 1 writable in both modes
// [RULE11] all enables cleared at reset
// [RULE12] bit 26 framing enable works both modes
// [RULE13] reserved bits read zero, ignore writes
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module lin_interrupt_enable_set
  import lin_irq_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  input wire logic lin_mode_i,
  input wire logic privileged_write_access_i,
  input wire logic [DATA_W-1:0] source_flags_i,
  output logic [DATA_W-1:0] irq_request_o,
  output logic irq_o
);

  reg_req_t req;
  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  logic [DATA_W-1:0] enable_reg;
  logic [DATA_W-1:0] enable_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [DATA_W-1:0] request_reg;
  logic [DATA_W-1:0] request_next;
  logic [EVT_W-1:0] evt_mask_reg;
  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] evt_pulse;
  logic [EVT_W-1:0] evt_clear;
  logic [DATA_W-1:0] write_mask;
  logic [DATA_W-1:0] effect_mask;
  logic hit_set;
  logic hit_clr;
  logic hit_status;
  logic hit_mask;

  lin_mode_filter lin_mode_filter_i (
    .lin_mode_i(lin_mode_i),
    .write_mask_o(write_mask),
    .effect_mask_o(effect_mask)
  );

  // address decode
  assign hit_set = (req.addr == OFS_IRQ_ENABLE_SET);
  assign hit_clr = (req.addr == OFS_IRQ_ENABLE_CLR);
  assign hit_status = (req.addr == OFS_EVT_STATUS);
  assign hit_mask = (req.addr == OFS_EVT_MASK);

  // ones set enables, zeros do nothing; mode gates which bits take it
  // the clear alias stands in for the companion clear register so tests can disable
  assign enable_next = (req.wr && hit_set) ? (enable_reg | (req.wdata & write_mask))
                     : (req.wr && hit_clr) ? (enable_reg & ~(req.wdata & write_mask))
                     : enable_reg; // see [RULE1] see [RULE8] see [RULE9] see [RULE10] see [RULE13]

  // read mux; privileged access does not change what is returned
  assign rdata_next = !req.rd ? '0
                    : (hit_set || hit_clr) ? (enable_reg & MASK_IMPL)
                    : hit_status ? {{(DATA_W-EVT_W){1'b0}}, evt_status}
                    : hit_mask ? {{(DATA_W-EVT_W){1'b0}}, evt_mask_reg}
                    : '0; // see [RULE2] see [RULE13]

  // requests reach the flag side only for enabled sources effective in this mode
  assign request_next = source_flags_i & enable_reg & effect_mask; // see [RULE3] see [RULE4] see [RULE5] see [RULE6] see [RULE7] see [RULE12]

  // enables reset to zero
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable_reg <= ENABLE_RESET; // see [RULE11]
      rdata_reg <= '0;
      request_reg <= '0;
      evt_mask_reg <= '0;
    end else begin
      enable_reg <= enable_next;
      rdata_reg <= rdata_next;
      request_reg <= request_next;
      if (req.wr && hit_mask) begin
        evt_mask_reg <= req.wdata[EVT_W-1:0];
      end
    end
  end

  // events: refused set attempt, and a new request appearing
  assign evt_pulse[EVT_SET_LOST] = req.wr && hit_set && |(req.wdata & MASK_IMPL & ~write_mask);
  assign evt_pulse[EVT_REQ_RISE] = |(request_next & ~request_reg);
  assign evt_clear = (req.wr && hit_status) ? req.wdata[EVT_W-1:0] : '0;

  lin_evt_status #(
    .WIDTH(EVT_W)
  ) lin_evt_status_i (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .event_i(evt_pulse),
    .clear_i(evt_clear),
    .mask_i(evt_mask_reg),
    .status_o(evt_status),
    .irq_o(irq_o)
  );

  assign reg_rdata_o = rdata_reg;
  assign irq_request_o = request_reg;

  // privileged flag is accepted but does not alter access in this block
  logic unused_priv;
  assign unused_priv = privileged_write_access_i;

  // checks
  AST_SET_STICKS: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (req.wr && hit_set && lin_mode_i && req.wdata[BIT_BIT_ERR]) |=> enable_reg[BIT_BIT_ERR])
    else $error("bit error enable not set"); // see [RULE1]
  AST_ZERO_KEEPS: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (req.wr && hit_set) |=> ((enable_reg & $past(enable_reg)) == $past(enable_reg)))
    else $error("write to set register cleared an enable"); // see [RULE1]
  AST_READ_BACK: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (req.rd && hit_set && !req.wr) |=> (reg_rdata_o == $past(enable_reg)))
    else $error("read data differ from enables"); // see [RULE2]
  AST_LIN_ERR_GATE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !lin_mode_i |=> (irq_request_o[31:27] == 5'h00))
    else $error("lin-only request outside lin mode"); // see [RULE3]
  AST_BUS_FAULT_REQ: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (lin_mode_i && source_flags_i[BIT_BUS_FAULT] && enable_reg[BIT_BUS_FAULT])
    |=> irq_request_o[BIT_BUS_FAULT])
    else $error("bus fault request missing"); // see [RULE4]
  AST_LIN_ONLY_WRITE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (!lin_mode_i && !enable_reg[BIT_ID_MATCH]) |=> !enable_reg[BIT_ID_MATCH])
    else $error("id match enable written outside lin mode"); // see [RULE8]
  AST_UART_ONLY_WRITE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (lin_mode_i && !enable_reg[BIT_BREAK]) |=> !enable_reg[BIT_BREAK])
    else $error("break enable written in lin mode"); // see [RULE9]
  AST_ANY_MODE_WRITE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (req.wr && hit_set && req.wdata[BIT_WAKEUP]) |=> enable_reg[BIT_WAKEUP])
    else $error("wakeup enable not set"); // see [RULE10]
  AST_FRAMING_BOTH: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (source_flags_i[BIT_FRAMING] && enable_reg[BIT_FRAMING]) |=> irq_request_o[BIT_FRAMING])
    else $error("framing request missing"); // see [RULE12]
  AST_RESERVED_ZERO: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (enable_reg & ~MASK_IMPL) == '0)
    else $error("reserved enable bit set"); // see [RULE13]
  AST_RESET_CLEAR: assert property (@(posedge clk_sys_i)
    $rose(rst_n_i) |-> (enable_reg == ENABLE_RESET))
    else $error("enables not clear after reset"); // see [RULE11]

  // each lin-only error source must pass once enabled in lin mode
  AST_BIT_ERR_REQ: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (lin_mode_i && source_flags_i[BIT_BIT_ERR] && enable_reg[BIT_BIT_ERR])
    |=> irq_request_o[BIT_BIT_ERR])
    else $error("bit error request missing"); // see [RULE3]
  AST_CHECKSUM_REQ: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (lin_mode_i && source_flags_i[BIT_CHECKSUM] && enable_reg[BIT_CHECKSUM])
    |=> irq_request_o[BIT_CHECKSUM])
    else $error("checksum request missing"); // see [RULE5]
  AST_SYNC_BAD_REQ: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (lin_mode_i && source_flags_i[BIT_SYNC_BAD] && enable_reg[BIT_SYNC_BAD])
    |=> irq_request_o[BIT_SYNC_BAD])
    else $error("bad sync request missing"); // see [RULE6]
  AST_NO_RESP_REQ: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (lin_mode_i && source_flags_i[BIT_NO_RESP] && enable_reg[BIT_NO_RESP])
    |=> irq_request_o[BIT_NO_RESP])
    else $error("missing response request absent"); // see [RULE7]

  // a request never appears for a source that was not enabled
  AST_REQ_NEEDS_ENABLE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    1'b1 |=> ((irq_request_o & ~$past(enable_reg)) == '0))
    else $error("request without enable"); // see [RULE3]

  // mode-gated writes land only in their own mode
  AST_ID_LIN_SET: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (req.wr && hit_set && lin_mode_i && req.wdata[BIT_ID_MATCH]) |=> enable_reg[BIT_ID_MATCH])
    else $error("id match enable not set in lin mode"); // see [RULE8]
  AST_TIMEOUT_LIN_ONLY: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (!lin_mode_i && !enable_reg[BIT_TIMEOUT]) |=> !enable_reg[BIT_TIMEOUT])
    else $error("timeout enable written outside lin mode"); // see [RULE8]
  AST_BREAK_UART_SET: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (req.wr && hit_set && !lin_mode_i && req.wdata[BIT_BREAK]) |=> enable_reg[BIT_BREAK])
    else $error("break enable not set in uart mode"); // see [RULE9]

  // receive and transmit enables take a set in either mode, the framing enable a set in uart mode
  AST_RX_ANY_MODE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (req.wr && hit_set && req.wdata[BIT_RX]) |=> enable_reg[BIT_RX])
    else $error("receive enable not set"); // see [RULE10]
  AST_TX_ANY_MODE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (req.wr && hit_set && req.wdata[BIT_TX]) |=> enable_reg[BIT_TX])
    else $error("transmit enable not set"); // see [RULE10]
  AST_FRAMING_UART_SET: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (req.wr && hit_set && !lin_mode_i && req.wdata[BIT_FRAMING]) |=> enable_reg[BIT_FRAMING])
    else $error("framing enable not set in uart mode"); // see [RULE12]

  // privileged access must not change what a read returns
  AST_PRIV_READ_SAME: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (req.rd && hit_set && !req.wr && privileged_write_access_i)
    |=> (reg_rdata_o == $past(enable_reg)))
    else $error("privileged read differs from enables"); // see [RULE2]

  // read data stand only in the cycle after a strobe and never show reserved bits
  AST_READ_IDLE_ZERO: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !req.rd |=> (reg_rdata_o == '0))
    else $error("read data without read strobe"); // see [RULE13]
  AST_READ_RESERVED_ZERO: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    req.rd |=> ((reg_rdata_o & ~MASK_IMPL) == '0))
    else $error("reserved bit read as one"); // see [RULE13]

endmodule : lin_interrupt_enable_set
`default_nettype wire

//--- design/lin_irq_pkg.sv
// package: offsets, bit positions and masks of the interrupt-enable set block
package lin_irq_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE_SET = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE_CLR = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 4'hc;

  // enable bit positions
  localparam int BIT_BIT_ERR = 31;
  localparam int BIT_BUS_FAULT = 30;
  localparam int BIT_CHECKSUM = 29;
  localparam int BIT_SYNC_BAD = 28;
  localparam int BIT_NO_RESP = 27;
  localparam int BIT_FRAMING = 26;
  localparam int BIT_OVERRUN = 25;
  localparam int BIT_PARITY = 24;
  localparam int BIT_ID_MATCH = 13;
  localparam int BIT_RX = 9;
  localparam int BIT_TX = 8;
  localparam int BIT_TOA3_WUS = 7;
  localparam int BIT_TOA_WUS = 6;
  localparam int BIT_TIMEOUT = 4;
  localparam int BIT_WAKEUP = 1;
  localparam int BIT_BREAK = 0;

  // writable only in lin mode
  localparam logic [DATA_W-1:0] MASK_LIN_ONLY = 32'hf80020d0;
  // writable only in uart-compatible mode
  localparam logic [DATA_W-1:0] MASK_UART_ONLY = 32'h00000001;
  // writable in either mode
  localparam logic [DATA_W-1:0] MASK_ANY_MODE = 32'h07000302;
  localparam logic [DATA_W-1:0] MASK_IMPL = MASK_LIN_ONLY | MASK_UART_ONLY | MASK_ANY_MODE;
  // sources effective only in lin mode
  localparam logic [DATA_W-1:0] MASK_LIN_EFFECT = 32'hf8000000;
  localparam logic [DATA_W-1:0] ENABLE_RESET = 32'h00000000;

  // sticky event status bits
  localparam int EVT_W = 2;
  localparam int EVT_SET_LOST = 0; // write of ones to an enable refused by mode
  localparam int EVT_REQ_RISE = 1; // gated request went active

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage : lin_irq_pkg

//--- design/lin_mode_filter.sv
// mode filter: which bits a write may touch and which sources may fire
`timescale 1ns/10ps
`default_nettype none
module lin_mode_filter
  import lin_irq_pkg::*;
(
  input wire logic lin_mode_i,
  output logic [DATA_W-1:0] write_mask_o,
  output logic [DATA_W-1:0] effect_mask_o
);

  // writable bits in the present mode; reserved bits never
  assign write_mask_o = MASK_ANY_MODE | (lin_mode_i ? MASK_LIN_ONLY : MASK_UART_ONLY);
  // lin-only error sources are gated off outside lin mode
  assign effect_mask_o = lin_mode_i ? MASK_IMPL : (MASK_IMPL & ~MASK_LIN_EFFECT);

endmodule : lin_mode_filter
`default_nettype wire

//--- tb/lin_interrupt_enable_set_tb.sv
// self-checking bench for the interrupt-enable set register
`timescale 1ns/10ps
`default_nettype none
module lin_interrupt_enable_set_tb;
  import lin_irq_pkg::*;
  `define CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin fail_count++; \
    $display("wrong value at %0t: got %h want %h", $time, (act), (exp)); end end
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [ADDR_W-1:0] reg_addr_i = 4'h0;
  logic [DATA_W-1:0] reg_wdata_i = 32'h00000000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [DATA_W-1:0] reg_rdata_o;
  logic lin_mode_i = 1'b1;
  logic privileged_write_access_i = 1'b0;
  logic [DATA_W-1:0] source_flags_i = 32'h00000000;
  logic [DATA_W-1:0] irq_request_o;
  logic irq_o;
  logic [DATA_W-1:0] d;
  int fail_count = 0;
  int comparisons = 0;
  lin_interrupt_enable_set lin_interrupt_enable_set_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .lin_mode_i(lin_mode_i),
    .privileged_write_access_i(privileged_write_access_i), .source_flags_i(source_flags_i),
    .irq_request_o(irq_request_o), .irq_o(irq_o));
  // 100 MHz system clock
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // one-cycle write strobe; released on the next edge so strobes never overlap
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // read data is only valid in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    v = reg_rdata_o;
  endtask : rd
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // request output, enables and an unmapped offset read zero out of reset
  task automatic t_reset();
    `CHK(irq_request_o, 32'h00000000);
    rd(OFS_IRQ_ENABLE_SET, d);
    `CHK(d, 32'h00000000);
    rd(4'h2, d);
    `CHK(d, 32'h00000000);
  endtask : t_reset
  // lin mode: all ones sets lin-only and any-mode bits, not reserved or uart-only ones
  task automatic t_lin_set();
    lin_mode_i <= 1'b1;
    wr(OFS_IRQ_ENABLE_SET, 32'hffffffff);
    rd(OFS_IRQ_ENABLE_SET, d);
    `CHK(d, 32'hff0023d2);
    wr(OFS_IRQ_ENABLE_SET, 32'h00000000);
    rd(OFS_IRQ_ENABLE_SET, d);
    `CHK(d, 32'hff0023d2);
    privileged_write_access_i <= 1'b1;
    rd(OFS_IRQ_ENABLE_SET, d);
    `CHK(d, 32'hff0023d2);
    privileged_write_access_i <= 1'b0;
  endtask : t_lin_set
  // uart mode: break enable writable, lin-only bits frozen
  task automatic t_uart();
    lin_mode_i <= 1'b0;
    wr(OFS_IRQ_ENABLE_CLR, 32'hffffffff);
    rd(OFS_IRQ_ENABLE_SET, d);
    `CHK(d, 32'hf80020d0);
    wr(OFS_IRQ_ENABLE_SET, 32'h00002011);
    rd(OFS_IRQ_ENABLE_SET, d);
    `CHK(d, 32'hf80020d1);
    wr(OFS_IRQ_ENABLE_SET, 32'h07000302);
    rd(OFS_IRQ_ENABLE_SET, d);
    `CHK(d, 32'hff0023d3);
  endtask : t_uart
  // request outputs follow flags and enables one cycle late, error bits gated by mode
  task automatic t_req();
    source_flags_i <= 32'hffffffff;
    repeat (3) @(posedge clk_sys_i);
    #1;
    `CHK(irq_request_o, 32'h070023d3);
    lin_mode_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    `CHK(irq_request_o, 32'hff0023d3);
    source_flags_i <= 32'h04000000;
    repeat (3) @(posedge clk_sys_i);
    #1;
    `CHK(irq_request_o, 32'h04000000);
    source_flags_i <= 32'h00000000;
  endtask : t_req
  // refused write raises sticky status; mask gates irq, write-one clears it
  task automatic t_irq();
    wr(OFS_EVT_STATUS, 32'h00000003);
    wr(OFS_EVT_MASK, 32'h00000001);
    rd(OFS_EVT_STATUS, d);
    `CHK(irq_o, 1'b0);
    lin_mode_i <= 1'b0;
    // only a set write with refused ones raises the lost-set event
    wr(OFS_IRQ_ENABLE_SET, 32'h00002000);
    #1;
    `CHK(irq_o, 1'b1);
    rd(OFS_EVT_STATUS, d);
    `CHK(d[EVT_SET_LOST], 1'b1);
    wr(OFS_EVT_STATUS, 32'h00000001);
    #1;
    `CHK(irq_o, 1'b0);
    rd(OFS_IRQ_ENABLE_SET, d);
    `CHK(d, 32'hff0023d3);
  endtask : t_irq
  // watchdog so a stuck run still ends with a verdict
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    fail_count++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_lin_set();
    t_uart();
    t_req();
    t_irq();
    summarize();
  end
endmodule : lin_interrupt_enable_set_tb
`default_nettype wire
